// >>> hw/adc_sequencer.sv
/*
 * Sequencer for a 10-bit successive-approximation converter with an
 * AXI4-Lite register port. Assumes a comparator on the analog side that
 * reports whether the held sample is at or above the DAC trial code,
 * and an RC oscillator tick that arrives synchronous to aclk.
 */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Rules for this block and for the software that drives it
// RULE1: Reset restores registers, stops module, aborts conversion
// RULE2: Completion loads results, clears go, sets flag
// RULE3: Power-on reset leaves result registers untouched
// RULE4: Zero acquisition field: go starts conversion at once
// RULE5: Nonzero field: sample programmed periods, then convert
// RULE6: Sampling resumes after each completed conversion
// RULE7: Go stays set through acquisition and conversion
// RULE8: Two conversion-clock periods idle before next acquisition
// RULE9: Software picks RC clock for sleep operation
// RULE10: RC clock adds delay before conversion starts
// RULE11: Reference select: supply rails or external pins
// RULE12: Conversion start disconnects holding capacitor
// RULE13: Successive approximation yields ten-bit code
// RULE14: Software polls go or awaits flag
// RULE15: Software allows acquisition time after channel change
// RULE16: Each shared pin analog or digital individually; here one 4-bit code k makes the pins below 15-k analog
// RULE17: Software sets analog pin directions to input
// RULE18: Software configures everything before switching on
// RULE19: Software clears flag, enables interrupts, then starts
// RULE20: Conversion takes eleven conversion-clock periods
// RULE21: Clearing go aborts, results keep old value
// RULE22: Seven conversion clock choices including RC
// RULE23: Acquisition counter loaded from three-bit field
module adc_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rc_tick,
	input wire logic cmp_high,
	output adc_seq_pkg::analog_out_type analog_out,
	output logic conv_irq_flag
);
	import adc_seq_pkg::*;

	// Whole module state in one record
	typedef struct packed {
		phase_type phase;
		logic [5:0] div_cnt;
		logic [4:0] wait_cnt;
		logic [3:0] step;
		logic [9:0] sar;
		logic [7:0] conv_control_a;
		logic [7:0] conv_control_b;
		logic [7:0] conv_control_c;
		logic [7:0] result_high;
		logic [7:0] result_low;
		logic irq_flag;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	state_type st; // Registered state
	state_type next_st; // Next state

	// Decoded register fields
	logic enable;
	logic go;
	logic [2:0] clock_sel;
	logic [2:0] acq_sel;
	logic rc_selected;
	logic tad_tick; // One-cycle pulse per conversion-clock period
	logic write_hit; // Write address and data both offered
	logic [9:0] trial_bit; // Bit currently being resolved

	assign enable = st.conv_control_a[POS_ENABLE];
	assign go = st.conv_control_a[POS_GO];
	assign clock_sel = st.conv_control_c[POS_CLOCK_SEL +: 3];
	assign acq_sel = st.conv_control_c[POS_ACQ_SEL +: 3];
	assign rc_selected = clock_sel[1] & clock_sel[0]; // x11 picks RC [RULE22]
	assign trial_bit = SAR_FIRST_TRIAL >> st.step;

	// Conversion clock: RC tick or a pulse from the divider
	always_comb begin
		if (rc_selected) begin
			tad_tick = rc_tick; // [RULE22]
		end else begin
			tad_tick = (st.div_cnt == DIV_LAST[clock_sel]); // Divide by 2 to 64 [RULE22]
		end
	end

	// Both write channels are taken together, one write at a time
	assign write_hit = awvalid & wvalid & ~st.bvalid;
	assign awready = write_hit;
	assign wready = write_hit;
	assign arready = ~st.rvalid;

	// Next-state logic: bus, registers and sequencer
	always_comb begin
		logic start_now;
		logic [4:0] acq_n;
		next_st = st;
		start_now = 1'b0;
		acq_n = ACQ_TADS[acq_sel]; // [RULE23]

		// Divider runs only while the module is on
		if (st.phase == PH_OFF || tad_tick || rc_selected) begin
			next_st.div_cnt = 6'h00;
		end else begin
			next_st.div_cnt = st.div_cnt + 6'h01;
		end

		// Response handshakes complete
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end

		// Register write, low byte lane only
		if (write_hit) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			if (wstrb[0]) begin
				unique case (awaddr)
					ADDR_CONV_CONTROL_A: next_st.conv_control_a = wdata[7:0] & MASK_CONTROL_A;
					ADDR_CONV_CONTROL_B: next_st.conv_control_b = wdata[7:0] & MASK_CONTROL_B;
					ADDR_CONV_CONTROL_C: next_st.conv_control_c = wdata[7:0] & MASK_CONTROL_C;
					ADDR_RESULT_HIGH: next_st.result_high = wdata[7:0];
					ADDR_RESULT_LOW: next_st.result_low = wdata[7:0];
					ADDR_IRQ_STATUS: next_st.irq_flag = wdata[POS_IRQ_FLAG];
					default: next_st.bresp = RESP_SLVERR;
				endcase
			end else if (!(awaddr inside {ADDR_CONV_CONTROL_A, ADDR_CONV_CONTROL_B,
					ADDR_CONV_CONTROL_C, ADDR_RESULT_HIGH, ADDR_RESULT_LOW, ADDR_IRQ_STATUS})) begin
				next_st.bresp = RESP_SLVERR;
			end
		end

		// Register read; go reads back the live phase [RULE7] [RULE14]
		if (arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			unique case (araddr)
				ADDR_CONV_CONTROL_A: next_st.rdata[7:0] = st.conv_control_a;
				ADDR_CONV_CONTROL_B: next_st.rdata[7:0] = st.conv_control_b;
				ADDR_CONV_CONTROL_C: next_st.rdata[7:0] = st.conv_control_c;
				ADDR_RESULT_HIGH: next_st.rdata[7:0] = st.result_high;
				ADDR_RESULT_LOW: next_st.rdata[7:0] = st.result_low;
				ADDR_IRQ_STATUS: next_st.rdata[POS_IRQ_FLAG] = st.irq_flag;
				default: next_st.rresp = RESP_SLVERR;
			endcase
		end

		// Sequencer; PH_OFF sees the freshly written enable, PH_SAMPLE the registered go
		unique case (st.phase)
			PH_OFF: begin
				if (next_st.conv_control_a[POS_ENABLE]) begin
					next_st.phase = PH_SAMPLE;
				end
			end
			PH_SAMPLE: begin
				if (go) begin
					if (rc_selected) begin
						next_st.phase = PH_RC_WAIT; // Lets sleep be entered first [RULE10]
						next_st.wait_cnt = 5'h00;
					end else begin
						start_now = 1'b1;
					end
				end
			end
			PH_RC_WAIT: begin
				if (st.wait_cnt == 5'(SLEEP_DELAY_CYCLES - 1)) begin
					start_now = 1'b1; // [RULE10]
				end else begin
					next_st.wait_cnt = st.wait_cnt + 5'h01;
				end
			end
			PH_ACQUIRE: begin
				// Count programmed periods, go remains set meanwhile [RULE5] [RULE7] [RULE23]
				if (tad_tick) begin
					if (st.wait_cnt == 5'h01) begin
						next_st.phase = PH_CONVERT; // [RULE5] [RULE23]
						next_st.sar = SAR_FIRST_TRIAL;
						next_st.step = 4'h0;
					end else begin
						next_st.wait_cnt = st.wait_cnt - 5'h01;
					end
				end
			end
			PH_CONVERT: begin
				if (tad_tick) begin
					if (st.step < 4'(RESULT_BITS)) begin
						// Keep or drop the trial bit, then try the next lower one [RULE13]
						if (!cmp_high) begin
							next_st.sar = st.sar & ~trial_bit;
						end
						next_st.sar = next_st.sar | (trial_bit >> 1);
						next_st.step = st.step + 4'h1;
					end else begin
						// Eleventh period: finish and publish [RULE20] [RULE2]
						if (st.conv_control_c[POS_RIGHT_JUSTIFY]) begin
							next_st.result_high = {6'h00, st.sar[9:8]};
							next_st.result_low = st.sar[7:0];
						end else begin
							next_st.result_high = st.sar[9:2];
							next_st.result_low = {st.sar[1:0], 6'h00};
						end
						next_st.conv_control_a[POS_GO] = 1'b0; // [RULE2]
						next_st.irq_flag = 1'b1; // Set wins over a same-cycle clear [RULE2]
						next_st.phase = PH_GAP;
						next_st.wait_cnt = 5'(GAP_TADS);
					end
				end
			end
			PH_GAP: begin
				// Idle gap, then sampling restarts by itself [RULE8] [RULE6]
				if (tad_tick) begin
					if (st.wait_cnt == 5'h01) begin
						next_st.phase = PH_SAMPLE; // [RULE6]
					end else begin
						next_st.wait_cnt = st.wait_cnt - 5'h01; // [RULE8]
					end
				end
			end
		endcase

		// Start: straight to conversion or through acquisition [RULE4] [RULE5]
		if (start_now) begin
			if (acq_n == 5'h00) begin
				next_st.phase = PH_CONVERT; // [RULE4]
				next_st.sar = SAR_FIRST_TRIAL;
				next_st.step = 4'h0;
			end else begin
				next_st.phase = PH_ACQUIRE; // [RULE5] [RULE23]
				next_st.wait_cnt = acq_n;
			end
		end

		// Software clearing go aborts; results stay as they were [RULE21] [RULE8]
		if (st.phase inside {PH_RC_WAIT, PH_ACQUIRE, PH_CONVERT} &&
				!next_st.conv_control_a[POS_GO] && !(st.phase == PH_CONVERT &&
				tad_tick && st.step == 4'(RESULT_BITS))) begin
			next_st.phase = PH_GAP; // [RULE21]
			next_st.wait_cnt = 5'(GAP_TADS);
			next_st.result_high = st.result_high;
			next_st.result_low = st.result_low;
		end

		// Switching the module off forces PH_OFF and clears go
		if (!next_st.conv_control_a[POS_ENABLE]) begin
			next_st.phase = PH_OFF;
			next_st.conv_control_a[POS_GO] = 1'b0;
		end

		// Reset: everything to defaults except the results [RULE1] [RULE3]
		if (!aresetn) begin
			next_st.phase = PH_OFF; // [RULE1]
			next_st.div_cnt = 6'h00;
			next_st.wait_cnt = 5'h00;
			next_st.step = 4'h0;
			next_st.sar = 10'h000;
			next_st.conv_control_a = RESET_CONTROL_A;
			next_st.conv_control_b = RESET_CONTROL_B;
			next_st.conv_control_c = RESET_CONTROL_C;
			next_st.result_high = st.result_high; // Left alone [RULE3]
			next_st.result_low = st.result_low; // [RULE3]
			next_st.irq_flag = 1'b0;
			next_st.bvalid = 1'b0;
			next_st.bresp = RESP_OKAY;
			next_st.rvalid = 1'b0;
			next_st.rdata = 32'h0000_0000;
			next_st.rresp = RESP_OKAY;
		end
	end

	// Single state register; reset is folded into next_st
	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	// Front-end drive; the whole record comes from one process, so one driver
	always_comb begin
		logic [3:0] cfg;
		cfg = st.conv_control_b[POS_PIN_CONFIG +: 4];
		// Capacitor leaves the pin once conversion starts [RULE12]
		analog_out.sample_connect = (st.phase == PH_SAMPLE) ||
			(st.phase == PH_RC_WAIT) || (st.phase == PH_ACQUIRE); // [RULE12]
		analog_out.channel = st.conv_control_a[POS_CHANNEL +: 4];
		analog_out.dac_code = st.sar; // [RULE13]
		analog_out.vref_pos_ext = st.conv_control_b[POS_VREF_POS_EXT]; // [RULE11]
		analog_out.vref_neg_ext = st.conv_control_b[POS_VREF_NEG_EXT]; // [RULE11]
		// Analog pin split: code k leaves pins below 15-k analog [RULE16]
		for (int i = 0; i < ANALOG_PINS; i++) begin
			analog_out.analog_pin_mask[i] = (i < (15 - int'(cfg))); // [RULE16]
		end
	end
	assign conv_irq_flag = st.irq_flag;

	// Bus outputs straight from the state register
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;

endmodule : adc_sequencer

`default_nettype wire

// >>> hw/adc_seq_pkg.sv
/*
 * Constants and types shared by the converter sequencer: register map,
 * field positions, reset values, timing counts and the carrier structs.
 * Assumes a 100 MHz system clock on aclk.
 */
package adc_seq_pkg;

	// Register byte addresses on the AXI4-Lite port
	localparam logic [7:0] ADDR_CONV_CONTROL_A = 8'h00;
	localparam logic [7:0] ADDR_CONV_CONTROL_B = 8'h04;
	localparam logic [7:0] ADDR_CONV_CONTROL_C = 8'h08;
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;

	// Field positions in conv_control_a
	localparam int POS_ENABLE = 0;
	localparam int POS_GO = 1;
	localparam int POS_CHANNEL = 2;
	// Field positions in conv_control_b
	localparam int POS_PIN_CONFIG = 0;
	localparam int POS_VREF_NEG_EXT = 4;
	localparam int POS_VREF_POS_EXT = 5;
	// Field positions in conv_control_c
	localparam int POS_CLOCK_SEL = 0;
	localparam int POS_ACQ_SEL = 3;
	localparam int POS_RIGHT_JUSTIFY = 7;
	// Field position in the interrupt status register
	localparam int POS_IRQ_FLAG = 0;

	// Reset values
	localparam logic [7:0] RESET_CONTROL_A = 8'h00;
	localparam logic [7:0] RESET_CONTROL_B = 8'h00;
	localparam logic [7:0] RESET_CONTROL_C = 8'h00;

	// Writable bit masks, unimplemented bits read as zero
	localparam logic [7:0] MASK_CONTROL_A = 8'h3F;
	localparam logic [7:0] MASK_CONTROL_B = 8'h3F;
	localparam logic [7:0] MASK_CONTROL_C = 8'hBF;

	// Converter geometry
	localparam int RESULT_BITS = 10;
	localparam int CONVERT_TADS = 11;
	localparam int GAP_TADS = 2;
	localparam int ANALOG_PINS = 13;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	// Acquisition length in conversion-clock periods, by acquisition_time_sel
	localparam logic [4:0] ACQ_TADS [8] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h14};
	// Divider terminal count by conv_clock_sel; the RC codes never use the divider
	localparam logic [5:0] DIV_LAST [8] = '{6'h01, 6'h07, 6'h1F, 6'h01, 6'h03, 6'h0F, 6'h3F, 6'h01};

	// Delay before an RC-clocked conversion, one instruction cycle
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int SLEEP_DELAY_NS = 40;
	localparam int SLEEP_DELAY_CYCLES = (SLEEP_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Sequencer phases
	typedef enum logic [2:0] {
		PH_OFF,
		PH_SAMPLE,
		PH_RC_WAIT,
		PH_ACQUIRE,
		PH_CONVERT,
		PH_GAP
	} phase_type;

	// Signals presented to the analog front end
	typedef struct packed {
		logic sample_connect;
		logic [3:0] channel;
		logic [9:0] dac_code;
		logic vref_pos_ext;
		logic vref_neg_ext;
		logic [ANALOG_PINS-1:0] analog_pin_mask;
	} analog_out_type;

endpackage : adc_seq_pkg

// >>> verification/adc_seq_asserts.sv
/* Concurrent checks on the converter sequencer ports.
 * Assumes it is bound onto adc_sequencer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts
	import adc_seq_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire adc_seq_pkg::analog_out_type analog_out,
	input wire logic conv_irq_flag
);
	// One clock domain, reset masks all but the reset check
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Reset empties the bus and parks the front end
	property p_reset;
		disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !conv_irq_flag && !analog_out.sample_connect;
	endproperty
	a_reset: assert property (p_reset) else $error("state survives reset");
	// Write answer one cycle after the take, held until accepted
	property p_wr_ans;
		awvalid && awready |=> bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	// Read answer likewise
	property p_rd_ans;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	// Capacitor leaves the pin exactly when the trial starts at midscale
	property p_start;
		$fell(analog_out.sample_connect) |-> analog_out.dac_code == 10'h200;
	endproperty
	a_start: assert property (p_start) else $error("conversion start code wrong");
	// Completion lands outside sampling and keeps an idle gap
	property p_done_idle;
		$rose(conv_irq_flag) |-> !analog_out.sample_connect [*2];
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("no idle gap");
	// Sampling comes back on its own after completion
	property p_resume;
		$rose(conv_irq_flag) |-> ##[1:300] analog_out.sample_connect;
	endproperty
	a_resume: assert property (p_resume) else $error("sampling not resumed");
	// Flag stands until software writes
	property p_flag_hold;
		conv_irq_flag && !(awvalid && awready) |=> conv_irq_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
endmodule : adc_seq_asserts
bind adc_sequencer adc_seq_asserts CHECK (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.analog_out(analog_out), .conv_irq_flag(conv_irq_flag));
`default_nettype wire

// >>> verification/analog_front_model.sv
/* Far side model: input source, holding capacitor, comparator, RC clock.
 * Assumes aclk and the sequencer's analog_out struct. */
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
	import adc_seq_pkg::*;
#(parameter int RC_PERIOD = 7)
(
	input wire logic aclk,
	input wire adc_seq_pkg::analog_out_type analog_out,
	input wire logic [9:0] level,
	output logic cmp_high,
	output logic rc_tick
);
	logic [9:0] held = 10'h000; // Charge on the capacitor
	int rc_count = 0; // Oscillator phase, runs free
	// Capacitor follows the pin only while connected
	always @(posedge aclk) begin
		if (analog_out.sample_connect) begin
			held <= level; // Channel pins are inputs, so the source level shows
		end
		rc_count <= (rc_count == RC_PERIOD - 1) ? 0 : rc_count + 1;
	end
	// Held sample against the trial code
	assign cmp_high = held >= analog_out.dac_code;
	assign rc_tick = rc_count == 0;
endmodule : analog_front_model
`default_nettype wire

// >>> verification/adc_sequencer_acquisition_control_tb.sv
/* Self-checking bench for the converter sequencer.
 * Assumes the analog front model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adc_sequencer_acquisition_control_tb;
	import adc_seq_pkg::*;
	typedef struct packed {
		logic [2:0] clk_sel;
		logic [2:0] acq_sel;
		logic right;
		logic [9:0] level;
	} row_type;
	localparam int RC_PERIOD = 7;
	localparam int TADS [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awready, wready, bvalid, arready, rvalid, cmp_high, rc_tick, conv_irq_flag;
	logic [1:0] bresp, rresp, resp;
	logic [9:0] level = 10'h000;
	analog_out_type analog_out;
	logic meas = 1'b0;
	logic flag_at_take = 1'b0; // Flag in the same cycle the read data was taken from
	int acq_cnt, conv_cnt, div, n, bad_count = 0, checked = 0;
	// Every clock choice, every delay, both formats; last two on RC
	row_type rows [8] = '{'{3'h0, 3'h0, 1'b1, 10'h2A5}, '{3'h4, 3'h1, 1'b0, 10'h3FF},
		'{3'h1, 3'h2, 1'b1, 10'h000}, '{3'h5, 3'h3, 1'b0, 10'h155},
		'{3'h2, 3'h4, 1'b1, 10'h200}, '{3'h6, 3'h5, 1'b0, 10'h1FF},
		'{3'h3, 3'h6, 1'b1, 10'h0AA}, '{3'h7, 3'h7, 1'b0, 10'h301}};
	adc_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.rc_tick(rc_tick), .cmp_high(cmp_high), .analog_out(analog_out),
		.conv_irq_flag(conv_irq_flag));
	analog_front_model #(.RC_PERIOD(RC_PERIOD)) PARTNER (.aclk(aclk), .analog_out(analog_out),
		.level(level), .cmp_high(cmp_high), .rc_tick(rc_tick));
	// 100 MHz clock
	initial begin
		forever #5 aclk = ~aclk;
	end
	// Phase timer: sampling cycles, then cycles until the flag
	always @(posedge aclk) begin
		if (meas && conv_irq_flag !== 1'b1) begin
			if (analog_out.sample_connect) acq_cnt++;
			else conv_cnt++;
		end
	end
	// Write with address and data together, hold until taken
	task automatic bus_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge aclk iff (awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk iff bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : bus_write
	// Read, data taken at the answer edge
	task automatic bus_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk iff arready);
		flag_at_take = conv_irq_flag;
		arvalid <= 1'b0;
		@(posedge aclk iff rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : bus_read
	// Bounded wait for the capacitor switch
	task automatic wait_sample(input logic v);
		for (int k = 0; k < 300 && analog_out.sample_connect !== v; k++) begin
			@(posedge aclk);
		end
	endtask : wait_sample
	task automatic complete_run();
		$display("Counts: %0d checked, %0d bad", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// Watchdog, far beyond the longest expected run
	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus_read(8'(4 * i), d, resp);
			`CHK(d, 32'h0)
		end
		// Reference choice and pin split
		bus_write(ADDR_CONV_CONTROL_B, 32'h1F, resp);
		`CHK({analog_out.vref_pos_ext, analog_out.vref_neg_ext, analog_out.analog_pin_mask}, 15'h2000)
		bus_write(ADDR_CONV_CONTROL_B, 32'h23, resp);
		`CHK({analog_out.vref_pos_ext, analog_out.vref_neg_ext, analog_out.analog_pin_mask}, 15'h4FFF)
		foreach (rows[i]) begin
			div = rows[i].clk_sel[1:0] == 2'b11 ? RC_PERIOD : 2 << {rows[i].clk_sel[1:0], rows[i].clk_sel[2]};
			n = TADS[rows[i].acq_sel];
			level <= rows[i].level;
			bus_write(ADDR_CONV_CONTROL_C, {24'h0, rows[i].right, 1'b0, rows[i].acq_sel, rows[i].clk_sel}, resp);
			bus_write(ADDR_IRQ_STATUS, 32'h0, resp);
			bus_write(ADDR_CONV_CONTROL_A, 32'(i << 2) | 32'h1, resp);
			repeat (4) @(posedge aclk);
			`CHK({analog_out.sample_connect, analog_out.channel}, {1'b1, 4'(i)})
			acq_cnt = 0;
			conv_cnt = 0;
			bus_write(ADDR_CONV_CONTROL_A, 32'(i << 2) | 32'h3, resp);
			meas = 1'b1;
			d = 32'h2;
			for (int k = 0; k < 1000 && d[POS_GO]; k++) begin
				bus_read(ADDR_CONV_CONTROL_A, d, resp);
				if (d[POS_GO]) `CHK(flag_at_take, 1'b0)
			end
			meas = 1'b0;
			`CHK({d[POS_GO], conv_irq_flag}, 2'b01)
			`CHK(acq_cnt >= (n > 0 ? (n - 1) * div : 0) && acq_cnt <= n * div + div + 6, 1'b1)
			`CHK(conv_cnt >= 10 * div - 1 && conv_cnt <= 11 * div + 2, 1'b1)
			bus_read(ADDR_RESULT_HIGH, d, resp);
			`CHK(d[7:0], rows[i].right ? {6'h0, rows[i].level[9:8]} : rows[i].level[9:2])
			bus_read(ADDR_RESULT_LOW, d, resp);
			`CHK(d[7:0], rows[i].right ? rows[i].level[7:0] : {rows[i].level[1:0], 6'h0})
			wait_sample(1'b1);
			`CHK(analog_out.sample_connect, 1'b1)
		end
		// Unmapped places answer with an error and no data
		bus_read(8'h18, d, resp);
		`CHK({resp, d}, {RESP_SLVERR, 32'h0})
		bus_write(8'h1C, 32'hFF, resp);
		`CHK(resp, RESP_SLVERR)
		// Abort in mid-conversion keeps the old result
		level <= 10'h3FE;
		bus_write(ADDR_IRQ_STATUS, 32'h0, resp);
		bus_write(ADDR_CONV_CONTROL_C, 32'h06, resp);
		bus_write(ADDR_CONV_CONTROL_A, 32'h03, resp);
		wait_sample(1'b0);
		repeat (100) @(posedge aclk);
		bus_write(ADDR_CONV_CONTROL_A, 32'h01, resp);
		repeat (200) @(posedge aclk);
		bus_read(ADDR_RESULT_LOW, d, resp);
		`CHK({conv_irq_flag, d[7:0]}, 9'h040)
		// Reset in mid-conversion, result survives
		bus_write(ADDR_CONV_CONTROL_A, 32'h03, resp);
		wait_sample(1'b0);
		repeat (50) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK({analog_out.sample_connect, conv_irq_flag}, 2'b00)
		bus_read(ADDR_CONV_CONTROL_A, d, resp);
		`CHK(d, 32'h0)
		bus_read(ADDR_RESULT_LOW, d, resp);
		`CHK(d[7:0], 8'h40)
		complete_run();
	end
endmodule : adc_sequencer_acquisition_control_tb
`default_nettype wire
